// ==== inc/fifo_clock_pkg.sv ====
// Function
// - Shared mode: one clock feeds both FIFOs
// - Shared clock derives from shared source input
// - Shared fast range uses high-frequency loop
// - Shared slow range uses low-frequency loop
// - Separate mode: independent input and output clocks
// - Input clock loop follows input range flag
// - Output clock loop follows output range flag
// - Shared-clock mode is the default
// - Wide counter divides clock, flashes LED 4
// - Heartbeat cleared by reset, counts after release
// - Optionally halve oscillator for FIFO source
// - Per-direction clocks returned only in separate mode
// - Shared clock returned only in shared mode
package fifo_clock_pkg;

  // System clock period
  localparam int CLOCK_PERIOD_NS = 100;

  // Loop acquisition times, in nanoseconds
  localparam int HF_LOCK_TIME_NS = 10000;
  localparam int LF_LOCK_TIME_NS = 40000;
  // Longest gap between source edges before lock is dropped
  localparam int STALL_TIME_NS   = 2000;

  // Least times round up, longest times round down
  localparam logic [11:0] HF_LOCK_CYCLES =
    12'((HF_LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [11:0] LF_LOCK_CYCLES =
    12'((LF_LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [11:0] STALL_CYCLES   =
    12'(STALL_TIME_NS / CLOCK_PERIOD_NS);

  // Speed threshold separating the two loop ranges
  localparam int FAST_RANGE_MIN_MHZ = 60;

  // Heartbeat and status lamp layout
  localparam int HEARTBEAT_WIDTH_DEF = 24;
  localparam int LED_COUNT           = 5;
  localparam int LED_HEARTBEAT       = 4;
  localparam int LED_SHARED_LOCK     = 0;
  localparam int LED_INPUT_LOCK      = 1;
  localparam int LED_OUTPUT_LOCK     = 2;
  localparam int LED_SPARE           = 3;

  // Reset values
  localparam logic [LED_COUNT-1:0] LED_RESET = 5'h00;

  // Synchronised pin slots
  localparam int PIN_COUNT  = 4;
  localparam int PIN_OSC    = 0;
  localparam int PIN_SHARED = 1;
  localparam int PIN_INPUT  = 2;
  localparam int PIN_OUTPUT = 3;

  // Loop state
  typedef enum logic [1:0] {
    DLL_IDLE,
    DLL_ACQUIRE,
    DLL_LOCKED
  } dll_state_t;

endpackage

// ==== src/dll_conditioner.sv ====
`timescale 1ns/1ps
// Behavioural clock conditioner with two lock ranges
module dll_conditioner (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic enable,
  input  wire logic fast_range,
  input  wire logic src_level,
  output logic      clock_out,
  output logic      locked,
  output logic      hf_used
);
  import fifo_clock_pkg::*;

  dll_state_t  state_ff;     // Loop state
  dll_state_t  nxt_state;    // Next loop state
  logic [11:0] lock_cnt_ff;  // Acquisition progress
  logic [11:0] gap_cnt_ff;   // Cycles since last source edge
  logic        prev_ff;      // Source level one cycle ago
  logic        hf_ff;        // Range captured at acquisition start
  logic        clock_out_ff; // Conditioned clock
  logic        locked_ff;    // Lock indication

  // Edge and stall detection on the already synchronised source
  wire         src_edge  = src_level != prev_ff;
  wire         stalled   = gap_cnt_ff == STALL_CYCLES;
  wire         start     = state_ff == DLL_IDLE && enable;
  // Range in force while acquiring
  wire         use_hf    = start ? fast_range : hf_ff;
  wire  [11:0] lock_need = use_hf ? HF_LOCK_CYCLES : LF_LOCK_CYCLES;
  wire         lock_done = lock_cnt_ff == lock_need - 12'h001;

  // Next-state selection
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DLL_IDLE: begin
        if (enable) begin
          nxt_state = DLL_ACQUIRE;
        end
      end
      DLL_ACQUIRE: begin
        if (!enable) begin
          nxt_state = DLL_IDLE;
        end else if (lock_done && !stalled) begin
          nxt_state = DLL_LOCKED;
        end
      end
      DLL_LOCKED: begin
        if (!enable) begin
          nxt_state = DLL_IDLE;
        end else if (stalled) begin
          nxt_state = DLL_ACQUIRE;
        end
      end
      default: nxt_state = DLL_IDLE;
    endcase
  end

  // State, range capture and outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= DLL_IDLE;
      hf_ff        <= 1'b0;
      clock_out_ff <= 1'b0;
      locked_ff    <= 1'b0;
      prev_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      hf_ff        <= enable ? use_hf : 1'b0;
      clock_out_ff <= (nxt_state == DLL_LOCKED) ? src_level : 1'b0;
      locked_ff    <= nxt_state == DLL_LOCKED;
      prev_ff      <= src_level;
    end
  end

  // Acquisition and gap counters; a stall restarts acquisition
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_ff <= 12'h000;
      gap_cnt_ff  <= 12'h000;
    end else begin
      if (nxt_state != DLL_ACQUIRE || stalled) begin
        lock_cnt_ff <= 12'h000;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 12'h001;
      end
      if (src_edge || !enable || stalled) begin
        gap_cnt_ff <= 12'h000;
      end else begin
        gap_cnt_ff <= gap_cnt_ff + 12'h001;
      end
    end
  end

  assign clock_out = clock_out_ff;
  assign locked    = locked_ff;
  assign hf_used   = hf_ff;

endmodule

// ==== src/fifo_clock_domain_config.sv ====
`timescale 1ns/1ps
// FIFO clock selection, conditioning and heartbeat lamp
module fifo_clock_domain_config #(
  parameter bit common_fifo_clock_select = 1'b1,
  parameter bit shared_clock_fast_range  = 1'b0,
  parameter bit input_clock_fast_range   = 1'b0,
  parameter bit output_clock_fast_range  = 1'b0,
  parameter bit halve_oscillator_clock   = 1'b1,
  parameter int HEARTBEAT_WIDTH          =
    fifo_clock_pkg::HEARTBEAT_WIDTH_DEF
) (
  input  wire logic                             clock,
  input  wire logic                             arst_n,
  input  wire logic                             oscillator,
  input  wire logic                             shared_fifo_clock_source,
  input  wire logic                             input_fifo_clock_source,
  input  wire logic                             output_fifo_clock_source,
  output logic                                  osc_fifo_clock_source,
  output logic                                  shared_fifo_clock,
  output logic                                  input_fifo_clock,
  output logic                                  output_fifo_clock,
  output logic                                  shared_locked,
  output logic                                  input_locked,
  output logic                                  output_locked,
  output logic                                  shared_hf_used,
  output logic                                  input_hf_used,
  output logic                                  output_hf_used,
  output logic [fifo_clock_pkg::LED_COUNT-1:0]  led
);
  import fifo_clock_pkg::*;

  // Refuse widths the heartbeat cannot serve
  if (HEARTBEAT_WIDTH < 2 || HEARTBEAT_WIDTH > 32) begin : g_bad_width
    $error("HEARTBEAT_WIDTH must lie between 2 and 32");
  end

  // Raw pins gathered for synchronisation
  wire  [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] sync1_ff;   // First stage, read by stage two only
  logic [PIN_COUNT-1:0] sync2_ff;   // Settled pin levels

  assign pins_raw[PIN_OSC]    = oscillator;
  assign pins_raw[PIN_SHARED] = shared_fifo_clock_source;
  assign pins_raw[PIN_INPUT]  = input_fifo_clock_source;
  assign pins_raw[PIN_OUTPUT] = output_fifo_clock_source;

  // Two-stage synchroniser for every foreign pin
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
      end else begin
        sync1_ff[i] <= pins_raw[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  // Mode decode; shared mode unless separate is chosen
  wire shared_mode   = common_fifo_clock_select;
  wire separate_mode = !common_fifo_clock_select;

  // Loop enables per mode; unused loops stay idle
  wire shared_en = shared_mode;
  wire input_en  = separate_mode;
  wire output_en = separate_mode;

  // Range flags, masked so the other mode's flags have no effect
  wire shared_fast = shared_mode & shared_clock_fast_range;
  wire input_fast  = separate_mode & input_clock_fast_range;
  wire output_fast = separate_mode & output_clock_fast_range;

  // Oscillator source: halved or passed straight through
  logic osc_prev_ff;  // Oscillator level one cycle ago
  logic osc_src_ff;   // FIFO clock source from the oscillator
  wire  osc_rise = sync2_ff[PIN_OSC] && !osc_prev_ff;
  wire  nxt_osc_src = halve_oscillator_clock ?
                      (osc_src_ff ^ osc_rise) :
                      sync2_ff[PIN_OSC];

  // Oscillator divider register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_prev_ff <= 1'b0;
      osc_src_ff  <= 1'b0;
    end else begin
      osc_prev_ff <= sync2_ff[PIN_OSC];
      osc_src_ff  <= nxt_osc_src;
    end
  end

  // Shared clock loop, fed by the shared source
  dll_conditioner u_shared_dll (
    .clock      (clock),
    .arst_n     (arst_n),
    .enable     (shared_en),
    .fast_range (shared_fast),
    .src_level  (sync2_ff[PIN_SHARED]),
    .clock_out  (shared_fifo_clock),
    .locked     (shared_locked),
    .hf_used    (shared_hf_used)
  );

  // Input FIFO clock loop
  dll_conditioner u_input_dll (
    .clock      (clock),
    .arst_n     (arst_n),
    .enable     (input_en),
    .fast_range (input_fast),
    .src_level  (sync2_ff[PIN_INPUT]),
    .clock_out  (input_fifo_clock),
    .locked     (input_locked),
    .hf_used    (input_hf_used)
  );

  // Output FIFO clock loop
  dll_conditioner u_output_dll (
    .clock      (clock),
    .arst_n     (arst_n),
    .enable     (output_en),
    .fast_range (output_fast),
    .src_level  (sync2_ff[PIN_OUTPUT]),
    .clock_out  (output_fifo_clock),
    .locked     (output_locked),
    .hf_used    (output_hf_used)
  );

  // Heartbeat divider
  logic [HEARTBEAT_WIDTH-1:0] beat_ff;      // Free-running count
  logic [LED_COUNT-1:0]       led_ff;       // Lamp drivers
  wire  [HEARTBEAT_WIDTH-1:0] nxt_beat =
    beat_ff + {{(HEARTBEAT_WIDTH-1){1'b0}}, 1'b1};

  // Lamp pattern: lock status low, heartbeat on the top lamp
  wire  [LED_COUNT-1:0] nxt_led;
  assign nxt_led[LED_SHARED_LOCK] = shared_locked;
  assign nxt_led[LED_INPUT_LOCK]  = input_locked;
  assign nxt_led[LED_OUTPUT_LOCK] = output_locked;
  assign nxt_led[LED_SPARE]       = 1'b0;
  assign nxt_led[LED_HEARTBEAT]   = nxt_beat[HEARTBEAT_WIDTH-1];

  // Counter cleared by reset, counting from the first edge after
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      beat_ff <= '0;
      led_ff  <= LED_RESET;
    end else begin
      beat_ff <= nxt_beat;
      led_ff  <= nxt_led;
    end
  end

  assign osc_fifo_clock_source = osc_src_ff;
  assign led                   = led_ff;

  // Checks on the selection and heartbeat
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Shared conditioned clock follows its source once locked
  sequence shared_lock_held;
    shared_locked ##1 shared_locked;
  endsequence

  property shared_follows_p;
    shared_lock_held |-> shared_fifo_clock == $past(sync2_ff[PIN_SHARED]);
  endproperty

  shared_follows_a : assert property (shared_follows_p)
    else $error("shared clock does not follow shared source");

  // Separate clocks follow their own sources once locked
  input_follows_a : assert property (
    input_locked |-> input_fifo_clock == $past(sync2_ff[PIN_INPUT]))
    else $error("input clock does not follow input source");

  output_follows_a : assert property (
    output_locked |-> output_fifo_clock == $past(sync2_ff[PIN_OUTPUT]))
    else $error("output clock does not follow output source");

  // Shared clock is silent outside shared mode
  shared_mode_only_a : assert property (
    !common_fifo_clock_select |-> !shared_fifo_clock && !shared_locked)
    else $error("shared clock active in separate mode");

  // Per-direction clocks silent outside separate mode
  separate_mode_only_a : assert property (
    common_fifo_clock_select |->
      !input_fifo_clock && !output_fifo_clock && !input_locked)
    else $error("direction clocks active in shared mode");

  // Loop range matches the applicable flag, other flags ignored
  shared_range_a : assert property (
    shared_locked |->
      shared_hf_used == (shared_clock_fast_range & shared_mode))
    else $error("shared loop range wrong");

  input_range_a : assert property (
    input_locked |-> input_hf_used == input_clock_fast_range)
    else $error("input loop range wrong");

  output_range_a : assert property (
    output_locked |-> output_hf_used == output_clock_fast_range)
    else $error("output loop range wrong");

  // Lock flags of the three loops, shared first
  wire  [2:0]  lock_vec = {output_locked, input_locked, shared_locked};
  logic [11:0] idle_run_ff [3];  // Cycles each loop has been unlocked

  // Unlocked run length per loop, saturating, cleared by lock
  for (genvar j = 0; j < 3; j++) begin : g_idle_run
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        idle_run_ff[j] <= 12'h000;                   // Count from release
      end else if (lock_vec[j]) begin
        idle_run_ff[j] <= 12'h000;                   // Locked: restart
      end else if (idle_run_ff[j] != 12'hFFF) begin
        idle_run_ff[j] <= idle_run_ff[j] + 12'h001;  // Still unlocked
      end
    end
  end

  // Lock is reached no sooner than the range's acquisition time
  shared_lock_time_a : assert property (
    $rose(shared_locked) |->
      idle_run_ff[0] >= (shared_hf_used ? HF_LOCK_CYCLES : LF_LOCK_CYCLES))
    else $error("shared loop locked too quickly");

  input_lock_time_a : assert property (
    $rose(input_locked) |->
      idle_run_ff[1] >= (input_hf_used ? HF_LOCK_CYCLES : LF_LOCK_CYCLES))
    else $error("input loop locked too quickly");

  output_lock_time_a : assert property (
    $rose(output_locked) |->
      idle_run_ff[2] >= (output_hf_used ? HF_LOCK_CYCLES : LF_LOCK_CYCLES))
    else $error("output loop locked too quickly");

  // A loop unlocked for a while gives a quiet clock and a dark lamp
  sequence unlocked_run(lk);
    !lk [*8];
  endsequence

  shared_quiet_a : assert property (
    unlocked_run(shared_locked) |->
      !shared_fifo_clock && !led[LED_SHARED_LOCK])
    else $error("shared clock or lamp active while unlocked");

  input_quiet_a : assert property (
    unlocked_run(input_locked) |->
      !input_fifo_clock && !led[LED_INPUT_LOCK])
    else $error("input clock or lamp active while unlocked");

  output_quiet_a : assert property (
    unlocked_run(output_locked) |->
      !output_fifo_clock && !led[LED_OUTPUT_LOCK])
    else $error("output clock or lamp active while unlocked");

  // Loops idle in this mode report no high range
  shared_idle_range_a : assert property (
    separate_mode |-> !shared_hf_used)
    else $error("idle shared loop reports high range");

  direction_idle_range_a : assert property (
    shared_mode |-> !input_hf_used && !output_hf_used)
    else $error("idle direction loop reports high range");

  // Lamp 4 changes only as the low count bits wrap to zero
  heartbeat_led_a : assert property (
    $changed(led[LED_HEARTBEAT]) |->
      beat_ff[HEARTBEAT_WIDTH-2:0] == '0 &&
      led[LED_HEARTBEAT] == beat_ff[HEARTBEAT_WIDTH-1])
    else $error("heartbeat lamp out of step with counter");

  // Count is zero at release, then advances by one
  heartbeat_reset_a : assert property (
    @(posedge clock) disable iff (1'b0)
    $rose(arst_n) |-> beat_ff == '0 ##1 beat_ff == 1)
    else $error("heartbeat did not restart from zero");

  // Lamp 4 stays dark for the first cycles after release
  heartbeat_dark_a : assert property (
    @(posedge clock) disable iff (1'b0)
    $rose(arst_n) |-> !led[LED_HEARTBEAT] ##1 !led[LED_HEARTBEAT])
    else $error("heartbeat lamp lit straight after reset");

  // Count wraps from all ones back to zero
  heartbeat_wrap_a : assert property (
    &beat_ff |=> beat_ff == '0)
    else $error("heartbeat count did not wrap");

  // Halved oscillator toggles once per settled rising edge
  osc_halve_a : assert property (
    halve_oscillator_clock && osc_rise |=>
      osc_fifo_clock_source != $past(osc_fifo_clock_source))
    else $error("halved oscillator source missed a toggle");

  osc_direct_a : assert property (
    !halve_oscillator_clock |=>
      osc_fifo_clock_source == $past(sync2_ff[PIN_OSC]))
    else $error("undivided oscillator source wrong");

  // Halved source holds between settled rising edges
  osc_halve_hold_a : assert property (
    halve_oscillator_clock && !osc_rise |=> $stable(osc_fifo_clock_source))
    else $error("halved oscillator source toggled without an edge");

endmodule

// ==== tb/fifo_clock_user_model.sv ====
`timescale 1ns/1ps
// User-side clock source: a level that toggles at a fixed rate while run
module fifo_clock_user_model #(
  parameter int HALF = 3  // Half period in system clock cycles
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic run,
  output logic      src
);
  int cnt;  // Cycles since the last toggle

  // Toggle every HALF cycles; a stopped source parks low, never floats
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      src <= 1'h0;
    end else if (!run) begin
      // Source stands still between runs
      cnt <= 0;
      src <= 1'h0;
    end else if (cnt == HALF - 1) begin
      // Half period done
      cnt <= 0;
      src <= ~src;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
// Compare two values, count the check and report a mismatch
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  err_count++; $display("Error at %0t: value mismatch", $time); end end

// Bench: instance 0 defaults, 1 separate clocks, 2 shared fast range
module tb;
  import fifo_clock_pkg::*;
  localparam int       HB_W = 4;         // Short heartbeat counter
  localparam bit [1:0] SEP  = 2'h1;      // Mode per instance 1..2
  localparam bit [1:0] FAST = 2'h2;      // Output fast flags 1..2, input inverse
  logic       clock;                     // System clock
  logic       arst_n;                    // Asynchronous reset
  logic       run;                       // Per-direction sources run
  logic       run_sh;                    // Shared source runs
  logic       osc, sh_src, in_src, out_src;  // Source pins
  logic [2:0] osc_o, sh_clk, in_clk, out_clk;  // Clocks per instance
  logic [2:0] sh_lk, in_lk, out_lk, sh_hf, in_hf, out_hf;  // Status
  logic [4:0] led_o [3];                 // Lamps per instance
  logic [4:0] hs, hi, ho, hk;            // Pin histories, bit 0 newest
  logic       pa;                        // Previous halved oscillator
  int         err_count, total_checks, cyc, n;

  // Clock and cycle count since reset release
  initial clock = 1'h0;
  always #50 clock = ~clock;
  always @(posedge clock) cyc <= arst_n ? cyc + 1 : 0;

  // Sources from user logic and the board oscillator
  fifo_clock_user_model #(.HALF(2)) osc_model (.clock(clock),
    .arst_n(arst_n), .run(run), .src(osc));
  fifo_clock_user_model #(.HALF(3)) sh_model (.clock(clock),
    .arst_n(arst_n), .run(run_sh), .src(sh_src));
  fifo_clock_user_model #(.HALF(5)) in_model (.clock(clock),
    .arst_n(arst_n), .run(run), .src(in_src));
  fifo_clock_user_model #(.HALF(7)) out_model (.clock(clock),
    .arst_n(arst_n), .run(run), .src(out_src));

  // Mode settings left at their defaults
  fifo_clock_domain_config #(.HEARTBEAT_WIDTH(HB_W))
    fifo_clock_domain_config_inst (.clock(clock), .arst_n(arst_n),
    .oscillator(osc), .shared_fifo_clock_source(sh_src),
    .input_fifo_clock_source(in_src), .output_fifo_clock_source(out_src),
    .osc_fifo_clock_source(osc_o[0]), .shared_fifo_clock(sh_clk[0]),
    .input_fifo_clock(in_clk[0]), .output_fifo_clock(out_clk[0]),
    .shared_locked(sh_lk[0]), .input_locked(in_lk[0]),
    .output_locked(out_lk[0]), .shared_hf_used(sh_hf[0]),
    .input_hf_used(in_hf[0]), .output_hf_used(out_hf[0]), .led(led_o[0]));

  // Separate mode with stray shared flag, and shared fast undivided
  for (genvar g = 1; g < 3; g++) begin : gen_dut
    fifo_clock_domain_config #(.common_fifo_clock_select(!SEP[g-1]),
      .shared_clock_fast_range(1'h1), .input_clock_fast_range(!FAST[g-1]),
      .output_clock_fast_range(FAST[g-1]), .halve_oscillator_clock(SEP[g-1]),
      .HEARTBEAT_WIDTH(HB_W))
      fifo_clock_domain_config_inst (.clock(clock), .arst_n(arst_n),
      .oscillator(osc), .shared_fifo_clock_source(sh_src),
      .input_fifo_clock_source(in_src), .output_fifo_clock_source(out_src),
      .osc_fifo_clock_source(osc_o[g]), .shared_fifo_clock(sh_clk[g]),
      .input_fifo_clock(in_clk[g]), .output_fifo_clock(out_clk[g]),
      .shared_locked(sh_lk[g]), .input_locked(in_lk[g]),
      .output_locked(out_lk[g]), .shared_hf_used(sh_hf[g]),
      .input_hf_used(in_hf[g]), .output_hf_used(out_hf[g]), .led(led_o[g]));
  end

  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Wait until the cycle count since release reaches k
  task automatic wait_to(input int k);
    while (cyc < k) @(negedge clock);
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    arst_n = 1'h0;
    run = 1'h0;
    run_sh = 1'h0;
    repeat (6) @(negedge clock);
    `CHECK(led_o[0], 5'h00)
    `CHECK({sh_lk, in_lk, out_lk, sh_clk}, 12'h000)
    repeat (6) @(posedge clock);
    arst_n <= 1'h1;
    run <= 1'h1;
    run_sh <= 1'h1;
    // Heartbeat: first rise after release, then half period of 8
    n = 0;
    while (led_o[0][4] !== 1'h1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    `CHECK(n >= 9 && n <= 10, 1'b1)
    n = 0;
    while (led_o[0][4] !== 1'h0 && n < 40) begin
      @(negedge clock);
      n++;
    end
    `CHECK(n, 8)
    // High range loops lock near 100 cycles
    wait_to(95);
    `CHECK(sh_lk[2], 1'h0)
    `CHECK(in_lk[1], 1'h0)
    wait_to(120);
    `CHECK({sh_lk[2], sh_hf[2]}, 2'h3)
    `CHECK({in_lk[1], in_hf[1]}, 2'h3)
    `CHECK({out_lk[1], sh_lk[0]}, 2'h0)
    // Low range loops lock near 400 cycles
    wait_to(395);
    `CHECK({out_lk[1], sh_lk[0]}, 2'h0)
    wait_to(420);
    `CHECK({sh_lk[0], sh_hf[0]}, 2'h2)
    `CHECK({out_lk[1], out_hf[1]}, 2'h2)
    `CHECK({sh_lk[1], sh_hf[1], sh_clk[1]}, 3'h0)
    `CHECK({in_lk[0], out_lk[0], in_clk[0], out_clk[0]}, 4'h0)
    `CHECK({in_hf[2], out_hf[2], in_clk[2], out_clk[2]}, 4'h0)
    `CHECK(led_o[0][3:0], 4'h1)
    `CHECK(led_o[1][3:0], 4'h6)
    // Conditioned clocks follow their own sources three cycles later
    for (int i = 0; i < 80; i++) begin
      @(negedge clock);
      hs = {hs[3:0], sh_src};
      hi = {hi[3:0], in_src};
      ho = {ho[3:0], out_src};
      hk = {hk[3:0], osc};
      if (i > 5) begin
        `CHECK(sh_clk[0], hs[3])
        `CHECK(sh_clk[2], hs[3])
        `CHECK(in_clk[1], hi[3])
        `CHECK(out_clk[1], ho[3])
        `CHECK(osc_o[2], hk[3])
        `CHECK(osc_o[0] ^ pa, hk[3] & ~hk[4])
      end
      pa = osc_o[0];
    end
    // Shared source stops: shared loops drop, separate ones hold
    @(posedge clock);
    run_sh <= 1'h0;
    repeat (30) @(negedge clock);
    `CHECK({sh_lk[0], sh_clk[0], sh_lk[2], sh_clk[2]}, 4'h0)
    `CHECK({in_lk[1], out_lk[1]}, 2'h3)
    // Reset in mid-run clears everything at once
    @(posedge clock);
    arst_n <= 1'h0;
    @(negedge clock);
    `CHECK(led_o[1], 5'h00)
    `CHECK({in_lk, out_lk, in_clk, out_clk, osc_o}, 15'h0000)
    end_of_test();
  end
endmodule
